// ===== pkg/pv_retransmit_pkg.sv
// Constants shared by the process-variable retransmit scaler and its scaling core.
// Assumes a single clock domain and an APB register bus with 32-bit data.
package pv_retransmit_pkg;

  // ==========================================================================
  // Sizes
  localparam int NUM_LOOPS = 4;
  localparam int NUM_CH    = 8;
  localparam int SRC_W     = 3;
  localparam int LOOP_W    = 2;
  localparam int CH_W      = 3;
  localparam int PV_W      = 16;
  localparam int PCT_W     = 7;
  localparam int OUT_W     = 14;
  localparam int NUM_W     = 30;

  // ==========================================================================
  // Scaling
  localparam logic [PCT_W-1:0] PCT_MAX   = 7'h64;
  localparam logic [OUT_W-1:0] OUT_SCALE = 14'h0064;
  localparam logic [4:0]       DIV_LAST  = 5'h1d;
  localparam logic [CH_W-1:0]  LAST_CH   = 3'h7;
  localparam logic [SRC_W-1:0] SRC_NONE  = 3'h0;
  localparam logic [SRC_W-1:0] SRC_MAX   = 3'h4;

  // ==========================================================================
  // Register map: channel base = channel * 0x20, channel = 2 * loop + cool
  localparam logic [4:0] OFF_SOURCE  = 5'h00;
  localparam logic [4:0] OFF_MIN_IN  = 5'h04;
  localparam logic [4:0] OFF_MAX_IN  = 5'h08;
  localparam logic [4:0] OFF_MIN_OUT = 5'h0c;
  localparam logic [4:0] OFF_MAX_OUT = 5'h10;
  localparam logic [4:0] OFF_RESULT  = 5'h14;

  // ==========================================================================
  // Reset values
  localparam logic [SRC_W-1:0] RST_SOURCE  = 3'h0;
  localparam logic [PV_W-1:0]  RST_MIN_IN  = 16'h0000;
  localparam logic [PV_W-1:0]  RST_MAX_IN  = 16'h03e8;
  localparam logic [PCT_W-1:0] RST_MIN_OUT = 7'h00;
  localparam logic [PCT_W-1:0] RST_MAX_OUT = 7'h64;
  localparam logic [OUT_W-1:0] RST_RESULT  = 14'h0000;

endpackage : pv_retransmit_pkg

// ===== hdl/pv_scale_core.sv
// Clamped linear scaling of one process variable onto an output in 0.01 % steps.
// Assumes start is a one-cycle pulse given only while busy is low; inputs are
// sampled on the start edge only.
`timescale 1ns/1ns
module pv_scale_core (
  input  wire logic                                      pclk,
  input  wire logic                                      presetn,
  input  wire logic                                      start,
  input  wire logic signed [pv_retransmit_pkg::PV_W-1:0] pv,
  input  wire logic signed [pv_retransmit_pkg::PV_W-1:0] range_lo,
  input  wire logic signed [pv_retransmit_pkg::PV_W-1:0] range_hi,
  input  wire logic signed [pv_retransmit_pkg::PV_W-1:0] lowest_scaled_input,
  input  wire logic signed [pv_retransmit_pkg::PV_W-1:0] highest_scaled_input,
  input  wire logic        [pv_retransmit_pkg::PCT_W-1:0] min_out,
  input  wire logic        [pv_retransmit_pkg::PCT_W-1:0] max_out,
  output logic                                           busy,
  output logic                                           done,
  output logic             [pv_retransmit_pkg::OUT_W-1:0] result
);

  typedef enum logic {C_IDLE, C_DIV} core_state_e;

  function automatic logic signed [15:0] clamp_s16(input logic signed [15:0] v,
                                                   input logic signed [15:0] lo,
                                                   input logic signed [15:0] hi);
    if (v < lo)
      clamp_s16 = lo;
    else if (v > hi)
      clamp_s16 = hi;
    else
      clamp_s16 = v;
  endfunction : clamp_s16

  // ==========================================================================
  // Operand preparation
  core_state_e        state_q;
  logic signed [15:0] lo_in_c;
  logic signed [15:0] hi_in_c;
  logic signed [15:0] pv_c;
  logic        [6:0]  top_pct;
  logic        [13:0] base_val;
  logic        [13:0] top_val;
  logic        [13:0] span_val;
  logic signed [16:0] den_s;
  logic signed [16:0] diff_s;
  logic               degenerate;
  logic        [29:0] num_w;

  assign lo_in_c    = clamp_s16(lowest_scaled_input, range_lo, range_hi); // RL10
  assign hi_in_c    = clamp_s16(highest_scaled_input, range_lo, range_hi); // RL10
  assign pv_c       = clamp_s16(pv, lo_in_c, hi_in_c); // RL5 RL8
  // An inverted output range collapses onto the lowest output setting
  assign top_pct    = (max_out < min_out) ? min_out : max_out; // RL7 RL9
  assign base_val   = {7'h00, min_out} * pv_retransmit_pkg::OUT_SCALE;
  assign top_val    = {7'h00, top_pct} * pv_retransmit_pkg::OUT_SCALE;
  assign span_val   = top_val - base_val;
  assign den_s      = {hi_in_c[15], hi_in_c} - {lo_in_c[15], lo_in_c};
  assign diff_s     = {pv_c[15], pv_c} - {lo_in_c[15], lo_in_c};
  assign degenerate = den_s[16] || (den_s == 17'h0_0000);
  assign num_w      = {14'h0000, diff_s[15:0]} * {16'h0000, span_val}; // RL12

  // ==========================================================================
  // Serial restoring divider, one quotient bit per cycle to keep area small
  logic [29:0] num_q;
  logic [29:0] quo_q;
  logic [15:0] den_q;
  logic [15:0] rem_q;
  logic [4:0]  cnt_q;
  logic [13:0] base_q;
  logic [13:0] top_q;
  logic        clamp_lo_q;
  logic        clamp_hi_q;
  logic        done_q;
  logic [13:0] result_q;
  logic [16:0] rem_t;
  logic        ge;
  logic [15:0] rem_next;
  logic [29:0] quo_next;

  assign rem_t    = {rem_q, num_q[29]};
  assign ge       = rem_t >= {1'h0, den_q};
  assign rem_next = ge ? 16'(rem_t - {1'h0, den_q}) : rem_t[15:0];
  assign quo_next = {quo_q[28:0], ge};

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      state_q    <= C_IDLE;
      num_q      <= 30'h0000_0000;
      quo_q      <= 30'h0000_0000;
      den_q      <= 16'h0000;
      rem_q      <= 16'h0000;
      cnt_q      <= 5'h00;
      base_q     <= 14'h0000;
      top_q      <= 14'h0000;
      clamp_lo_q <= 1'h0;
      clamp_hi_q <= 1'h0;
      done_q     <= 1'h0;
      result_q   <= pv_retransmit_pkg::RST_RESULT;
    end
    else
    begin
      done_q <= 1'h0;
      unique case (state_q)
        C_IDLE:
          if (start)
          begin
            base_q     <= base_val;
            top_q      <= top_val;
            clamp_lo_q <= pv <= lo_in_c;
            // A collapsed input range gives the lowest output, never the top one
            clamp_hi_q <= (pv >= hi_in_c) && !degenerate;
            num_q      <= num_w;
            den_q      <= den_s[15:0];
            rem_q      <= 16'h0000;
            quo_q      <= 30'h0000_0000;
            cnt_q      <= 5'h00;
            if (degenerate)
            begin
              result_q <= base_val;
              done_q   <= 1'h1;
            end
            else
              state_q <= C_DIV;
          end
        C_DIV:
        begin
          rem_q <= rem_next;
          quo_q <= quo_next;
          num_q <= {num_q[28:0], 1'h0};
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == pv_retransmit_pkg::DIV_LAST)
          begin
            result_q <= base_q + quo_next[13:0]; // RL1 RL12
            done_q   <= 1'h1;
            state_q  <= C_IDLE;
          end
        end
      endcase
    end

  assign busy   = state_q != C_IDLE;
  assign done   = done_q;
  assign result = result_q;

  // ==========================================================================
  // Checks
  sequence s_finished;
    ##[1:31] done_q;
  endsequence

  AST_CORE_LATENCY: assert property (@(posedge pclk) disable iff (!presetn) // RL12
    start && !busy |-> s_finished) else $error("Scaling did not finish in time");
  AST_LOW_CLAMP: assert property (@(posedge pclk) disable iff (!presetn) // RL5
    done_q && clamp_lo_q |-> result_q == base_q) else $error("Low clamp value wrong");
  AST_HIGH_CLAMP: assert property (@(posedge pclk) disable iff (!presetn) // RL8
    done_q && clamp_hi_q && !clamp_lo_q |-> result_q == top_q)
    else $error("High clamp value wrong");
  AST_FLOOR: assert property (@(posedge pclk) disable iff (!presetn) // RL7
    done_q |-> result_q >= base_q) else $error("Output below lowest setting");
  AST_CEILING: assert property (@(posedge pclk) disable iff (!presetn) // RL9
    done_q |-> result_q <= top_q) else $error("Output above highest setting");
  AST_INPUT_RANGE: assert property (@(posedge pclk) disable iff (!presetn) // RL10
    range_lo <= range_hi |-> lo_in_c >= range_lo && hi_in_c <= range_hi)
    else $error("Input setting outside measurement range");

endmodule : pv_scale_core

// ===== hdl/pv_retransmit_scaler.sv
// Retransmit scaler: maps a loop's process variable onto any heat or cool output.
// Assumes an APB master on pclk, process values and PID demands from pclk logic,
// and an external converter that turns the output value into current or voltage.
//
// Operation
// RL1 - Output is linear and proportional to the source loop's process variable.
// RL2 - Any heat or cool output may retransmit any loop, including its own.
// RL3 - An output assigned to retransmission is not driven by PID control.
// RL4 - Heat and cool have identical separate settings; source none disables retransmit.
// RL5 - Process variable below lowest input holds output at lowest output value.
// RL6 - Lowest and highest output settings accept 0 to 100 percent.
// RL7 - Output never drops below a nonzero lowest output setting.
// RL8 - Process variable above highest input holds output at highest output value; with a collapsed input range the code gives the lowest instead.
// RL9 - Output never exceeds the highest output percentage; when that is set below the lowest, the code uses the lowest instead.
// RL10 - Input settings are in source units, limited to its measurement range.
// RL11 - External converter turns the output into 4-20 mA or 0-5 V.
// RL12 - Linear interpolation between clamps, recomputed on every control update.
`timescale 1ns/1ns
module pv_retransmit_scaler (
  input  wire logic                                                   pclk,
  input  wire logic                                                   presetn,
  input  wire logic                                                   psel,
  input  wire logic                                                   penable,
  input  wire logic                                                   pwrite,
  input  wire logic [7:0]                                             paddr,
  input  wire logic [31:0]                                            pwdata,
  input  wire logic [3:0]                                             pstrb,
  output logic      [31:0]                                            prdata,
  output logic                                                        pready,
  output logic                                                        pslverr,
  input  wire logic                                                   update_tick,
  input  wire logic [pv_retransmit_pkg::NUM_LOOPS-1:0][15:0]          pv,
  input  wire logic [pv_retransmit_pkg::NUM_LOOPS-1:0][15:0]          pv_range_lo,
  input  wire logic [pv_retransmit_pkg::NUM_LOOPS-1:0][15:0]          pv_range_hi,
  input  wire logic [pv_retransmit_pkg::NUM_LOOPS-1:0][13:0]          pid_heat,
  input  wire logic [pv_retransmit_pkg::NUM_LOOPS-1:0][13:0]          pid_cool,
  output logic      [pv_retransmit_pkg::NUM_LOOPS-1:0][13:0]          heat_drive,
  output logic      [pv_retransmit_pkg::NUM_LOOPS-1:0][13:0]          cool_drive,
  output logic      [pv_retransmit_pkg::NUM_CH-1:0]                   retrans_active
);

  typedef enum logic [1:0] {S_IDLE, S_PICK, S_WAIT} sweep_state_e;

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wdata,
                                          input logic [3:0]  strb);
    merge16 = {strb[1] ? wdata[15:8] : old[15:8], strb[0] ? wdata[7:0] : old[7:0]};
  endfunction : merge16

  function automatic logic [6:0] sat_pct(input logic [7:0] wbyte);
    sat_pct = (wbyte > {1'h0, pv_retransmit_pkg::PCT_MAX}) ? pv_retransmit_pkg::PCT_MAX
                                                           : wbyte[6:0];
  endfunction : sat_pct

  // ==========================================================================
  // Per-channel settings; even channels are heat outputs, odd ones cool
  logic [2:0]  src_q     [pv_retransmit_pkg::NUM_CH];
  logic [15:0] lowest_scaled_input_q [pv_retransmit_pkg::NUM_CH];
  logic [15:0] highest_scaled_input_q [pv_retransmit_pkg::NUM_CH];
  logic [6:0]  min_out_q [pv_retransmit_pkg::NUM_CH];
  logic [6:0]  max_out_q [pv_retransmit_pkg::NUM_CH];
  logic [13:0] out_q     [pv_retransmit_pkg::NUM_CH];

  // ==========================================================================
  // APB decode
  logic [2:0]  a_ch;
  logic [4:0]  a_off;
  logic        hit_src;
  logic        hit_min_in;
  logic        hit_max_in;
  logic        hit_min_out;
  logic        hit_max_out;
  logic        hit_result;
  logic        mapped;
  logic        bad_access;
  logic        setup_ph;
  logic        access_ph;
  logic        wr_en;
  logic [31:0] rd_word;
  logic [2:0]  w_src;
  logic [31:0] prdata_q;
  logic        pslverr_q;

  assign a_ch        = paddr[7:5];
  assign a_off       = paddr[4:0];
  assign hit_src     = a_off == pv_retransmit_pkg::OFF_SOURCE;
  assign hit_min_in  = a_off == pv_retransmit_pkg::OFF_MIN_IN;
  assign hit_max_in  = a_off == pv_retransmit_pkg::OFF_MAX_IN;
  assign hit_min_out = a_off == pv_retransmit_pkg::OFF_MIN_OUT;
  assign hit_max_out = a_off == pv_retransmit_pkg::OFF_MAX_OUT;
  assign hit_result  = a_off == pv_retransmit_pkg::OFF_RESULT;
  assign mapped      = hit_src || hit_min_in || hit_max_in || hit_min_out
                       || hit_max_out || hit_result;
  // The result register is read-only, so a write to it is refused like a miss
  assign bad_access  = !mapped || (pwrite && hit_result);
  assign setup_ph    = psel && !penable;
  assign access_ph   = psel && penable;
  assign wr_en       = access_ph && pwrite && !bad_access;
  // Unknown loop numbers are stored as none rather than pointing nowhere
  assign w_src       = (pwdata[2:0] > pv_retransmit_pkg::SRC_MAX || pwdata[7:3] != 5'h00)
                       ? pv_retransmit_pkg::SRC_NONE : pwdata[2:0]; // RL4

  assign rd_word = hit_src     ? {29'h0000_0000, src_q[a_ch]} :
                   hit_min_in  ? {16'h0000, lowest_scaled_input_q[a_ch]} :
                   hit_max_in  ? {16'h0000, highest_scaled_input_q[a_ch]} :
                   hit_min_out ? {25'h000_0000, min_out_q[a_ch]} :
                   hit_max_out ? {25'h000_0000, max_out_q[a_ch]} :
                   hit_result  ? {18'h0_0000, out_q[a_ch]} : 32'h0000_0000;

  // Read data is captured in the setup cycle so it comes from a flip-flop
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'h0;
    end
    else if (setup_ph)
    begin
      prdata_q  <= pwrite ? 32'h0000_0000 : rd_word;
      pslverr_q <= bad_access;
    end

  assign pready  = access_ph;
  assign pslverr = access_ph && pslverr_q;
  assign prdata  = prdata_q;

  // ==========================================================================
  // Settings registers; percentages saturate at full scale
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      for (int c = 0; c < pv_retransmit_pkg::NUM_CH; c++)
      begin
        src_q[c]     <= pv_retransmit_pkg::RST_SOURCE;
        lowest_scaled_input_q[c] <= pv_retransmit_pkg::RST_MIN_IN;
        highest_scaled_input_q[c] <= pv_retransmit_pkg::RST_MAX_IN;
        min_out_q[c] <= pv_retransmit_pkg::RST_MIN_OUT;
        max_out_q[c] <= pv_retransmit_pkg::RST_MAX_OUT;
      end
    end
    else if (wr_en)
    begin
      if (hit_src && pstrb[0])
        src_q[a_ch] <= w_src; // RL2 RL4
      if (hit_min_in)
        lowest_scaled_input_q[a_ch] <= merge16(lowest_scaled_input_q[a_ch], pwdata, pstrb);
      if (hit_max_in)
        highest_scaled_input_q[a_ch] <= merge16(highest_scaled_input_q[a_ch], pwdata, pstrb);
      if (hit_min_out && pstrb[0])
        min_out_q[a_ch] <= sat_pct(pwdata[7:0]); // RL6
      if (hit_max_out && pstrb[0])
        max_out_q[a_ch] <= sat_pct(pwdata[7:0]); // RL6
    end

  // ==========================================================================
  // Update sweep over all channels, one scaling at a time
  sweep_state_e state_q;
  logic [2:0]   ch_q;
  logic         pending_q;
  logic         sweep_go;
  logic         ch_active;
  logic         last_ch;
  logic [2:0]   sel_src;
  logic [1:0]   sel_loop;
  logic [2:0]   sel_loop_w;
  logic         core_start;
  logic         core_busy;
  logic         core_done;
  logic [13:0]  core_result;

  assign sweep_go   = (state_q == S_IDLE) && (pending_q || update_tick);
  assign sel_src    = src_q[ch_q];
  assign ch_active  = sel_src != pv_retransmit_pkg::SRC_NONE;
  assign sel_loop_w = sel_src - 3'h1;
  assign sel_loop   = sel_loop_w[1:0];
  assign last_ch    = ch_q == pv_retransmit_pkg::LAST_CH;
  assign core_start = (state_q == S_PICK) && ch_active;

  // A tick arriving mid-sweep is remembered so no control update is lost
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      pending_q <= 1'h0;
    else
      pending_q <= (update_tick && !sweep_go) || (pending_q && !sweep_go); // RL12

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      state_q <= S_IDLE;
      ch_q    <= 3'h0;
    end
    else
      unique case (state_q)
        S_IDLE:
          if (sweep_go)
          begin
            ch_q    <= 3'h0;
            state_q <= S_PICK;
          end
        S_PICK:
          if (ch_active)
            state_q <= S_WAIT;
          else if (last_ch)
            state_q <= S_IDLE;
          else
            ch_q <= ch_q + 3'h1;
        S_WAIT:
          if (core_done)
          begin
            state_q <= last_ch ? S_IDLE : S_PICK;
            ch_q    <= last_ch ? ch_q : ch_q + 3'h1;
          end
        default:
          state_q <= S_IDLE;
      endcase

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      for (int c = 0; c < pv_retransmit_pkg::NUM_CH; c++)
        out_q[c] <= pv_retransmit_pkg::RST_RESULT;
    end
    else if (state_q == S_WAIT && core_done)
      out_q[ch_q] <= core_result; // RL12

  pv_scale_core u_core (
    .pclk     (pclk),
    .presetn  (presetn),
    .start    (core_start),
    .pv       (pv[sel_loop]),
    .range_lo (pv_range_lo[sel_loop]),
    .range_hi (pv_range_hi[sel_loop]),
    .lowest_scaled_input  (lowest_scaled_input_q[ch_q]),
    .highest_scaled_input  (highest_scaled_input_q[ch_q]),
    .min_out  (min_out_q[ch_q]),
    .max_out  (max_out_q[ch_q]),
    .busy     (core_busy),
    .done     (core_done),
    .result   (core_result)
  );

  // ==========================================================================
  // Output drive: retransmission takes the output away from PID control
  logic [pv_retransmit_pkg::NUM_LOOPS-1:0][13:0] heat_q;
  logic [pv_retransmit_pkg::NUM_LOOPS-1:0][13:0] cool_q;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      heat_q <= '0;
      cool_q <= '0;
    end
    else
      for (int l = 0; l < pv_retransmit_pkg::NUM_LOOPS; l++)
      begin
        heat_q[l] <= retrans_active[2*l] ? out_q[2*l] : pid_heat[l]; // RL3 RL4
        cool_q[l] <= retrans_active[2*l+1] ? out_q[2*l+1] : pid_cool[l]; // RL3 RL4
      end

  assign heat_drive = heat_q;
  assign cool_drive = cool_q;

  always_comb
    for (int c = 0; c < pv_retransmit_pkg::NUM_CH; c++)
      retrans_active[c] = src_q[c] != pv_retransmit_pkg::SRC_NONE; // RL3

  // ==========================================================================
  // Checks
  sequence s_sweep_back;
    ##[1:300] (state_q == S_IDLE);
  endsequence

  AST_SWEEP_ENDS: assert property (@(posedge pclk) disable iff (!presetn) // RL12
    sweep_go |-> s_sweep_back) else $error("Update sweep did not finish");
  AST_STORE_RESULT: assert property (@(posedge pclk) disable iff (!presetn) // RL12
    state_q == S_WAIT && core_done |=> out_q[$past(ch_q)] == $past(core_result))
    else $error("Scaled result not stored");
  AST_START_IDLE: assert property (@(posedge pclk) disable iff (!presetn) // RL12
    core_start |-> !core_busy) else $error("Scaling started while busy");

  for (genvar g = 0; g < pv_retransmit_pkg::NUM_LOOPS; g++)
  begin : g_chk
    AST_PID_PASS: assert property (@(posedge pclk) disable iff (!presetn) // RL4
      src_q[2*g] == pv_retransmit_pkg::SRC_NONE |=> heat_q[g] == $past(pid_heat[g]))
      else $error("Heat output not passing PID demand");
    AST_RETRANS_PATH: assert property (@(posedge pclk) disable iff (!presetn) // RL3
      src_q[2*g+1] != pv_retransmit_pkg::SRC_NONE |=> cool_q[g] == $past(out_q[2*g+1]))
      else $error("Cool output driven by PID while retransmitting");
    AST_PCT_RANGE: assert property (@(posedge pclk) disable iff (!presetn) // RL6
      min_out_q[2*g] <= pv_retransmit_pkg::PCT_MAX && max_out_q[2*g] <= pv_retransmit_pkg::PCT_MAX)
      else $error("Output percentage setting out of range");
  end

endmodule : pv_retransmit_scaler

// ===== test/drive_converter.sv
// Model of the external converter fed by one retransmit drive output.
// Assumes the drive is in 0.01 % steps, 0 to 10000, as the scaler produces it.
`timescale 1ns/1ns
module drive_converter (
  input  wire logic [13:0] drive,
  output logic      [15:0] current_ua
);
  // ==========================================================================
  // Conversion
  // 4 mA offset plus 16 mA span in microamps; integer division loses under 2 uA
  assign current_ua = 16'(32'h0000_0fa0 + (32'(drive) * 32'h0000_0010) / 32'h0000_000a);
endmodule : drive_converter

// ===== test/tb.sv
// Self-checking bench for the retransmit scaler, driven over APB.
// Assumes zero-wait APB and a full sweep well under 300 cycles after a tick.
`timescale 1ns/1ns
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("ERROR %0t: got %h exp %h", $time, (a), (e)); end end
module tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, tick = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [3:0]  pstrb = 4'hf;
  logic        pready, pslverr, er;
  logic [3:0][15:0] pv_in = '0, rlo = '0, rhi = {4{16'h03e8}};
  logic [3:0][13:0] pid_h = {4{14'h0123}}, pid_c = {4{14'h0456}}, heat, cool;
  logic [7:0]  active;
  logic [15:0] cur;
  int n_fail = 0, n_checks = 0;
  pv_retransmit_scaler pv_retransmit_scaler_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .update_tick(tick), .pv(pv_in),
    .pv_range_lo(rlo), .pv_range_hi(rhi), .pid_heat(pid_h), .pid_cool(pid_c),
    .heat_drive(heat), .cool_drive(cool), .retrans_active(active));
  drive_converter drive_converter_inst (.drive(heat[1]), .current_ua(cur));
  always #4 pclk = ~pclk;
  // ==========================================================================
  // Bus and sweep helpers
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so a following transfer never assigns psel twice in one time step
    @(posedge pclk);
  endtask : apb
  task automatic sweep;
    tick <= 1'b1;
    @(posedge pclk);
    tick <= 1'b0;
    repeat (300) @(posedge pclk);
  endtask : sweep
  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    apb(1'b0, 8'h00, '0); `CHK(rd, 32'h0000_0000)
    apb(1'b0, 8'h08, '0); `CHK(rd, 32'h0000_03e8)
    apb(1'b0, 8'h10, '0); `CHK(rd, 32'h0000_0064)
    `CHK(active, 8'h00)
    `CHK(heat[0], 14'h0123)
  endtask : t_reset
  task automatic t_scale;
    pv_in[0] <= 16'h01f4;
    apb(1'b1, 8'h40, 32'h0000_0001);
    apb(1'b1, 8'h4c, 32'h0000_0014);
    sweep();
    apb(1'b0, 8'h54, '0); `CHK(rd, 32'h0000_1770)
    `CHK(heat[1], 14'h1770)
    `CHK(active[2], 1'b1)
    `CHK(cur, 16'h3520)
  endtask : t_scale
  task automatic t_clamp;
    pv_in[0] <= 16'hffce;
    sweep();
    `CHK(heat[1], 14'h07d0)
    pv_in[0] <= 16'h05dc;
    sweep();
    `CHK(heat[1], 14'h2710)
    apb(1'b1, 8'h50, 32'h0000_0032);
    sweep();
    `CHK(heat[1], 14'h1388)
  endtask : t_clamp
  task automatic t_own;
    pv_in[1] <= 16'h00fa;
    apb(1'b1, 8'h60, 32'h0000_0002);
    apb(1'b1, 8'h68, 32'h0000_1388);
    sweep();
    `CHK(cool[1], 14'h09c4)
    `CHK(heat[1], 14'h1388)
    apb(1'b1, 8'h6c, 32'h0000_0078);
    apb(1'b0, 8'h6c, '0); `CHK(rd, 32'h0000_0064)
  endtask : t_own
  task automatic t_err;
    apb(1'b0, 8'h18, '0); `CHK(er, 1'b1)
    apb(1'b1, 8'h54, 32'h0000_0000); `CHK(er, 1'b1)
    apb(1'b1, 8'h40, 32'h0000_0000);
    @(posedge pclk);
    `CHK(active[2], 1'b0)
    `CHK(heat[1], 14'h0123)
    pstrb <= 4'h2;
    apb(1'b1, 8'h44, 32'h0000_abcd);
    pstrb <= 4'hf;
    apb(1'b0, 8'h44, '0); `CHK(rd, 32'h0000_ab00)
  endtask : t_err
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize
  // ==========================================================================
  // Main sequence and watchdog
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_scale();
    t_clamp();
    t_own();
    t_err();
    summarize();
  end
  // Five sweeps of 300 cycles plus bus traffic fit well inside this span
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    summarize();
  end
endmodule : tb
